// ==== psd_pkg.sv ====
package psd_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS = 8'h08;
    localparam logic [7:0] LIVE_OFS = 8'h0c;
    localparam logic [7:0] OPEN_OFS = 8'h10;

    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_PD_OFF_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h1;

    localparam int ST_LOCK_LOST_BIT = 0;
    localparam int ST_LOCK_GAIN_BIT = 1;
    localparam int ST_FV_BIT = 2;
    localparam int ST_FR_BIT = 3;
    localparam int ST_W = 4;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [17:0] OPEN_RST = 18'h00000;

    localparam int LIVE_RA_POS = 16;
    localparam int LIVE_LOCK_POS = 20;

    // ------------------------------------------------------------------
    // Divider constants
    // ------------------------------------------------------------------
    localparam int N_PIN_W = 14;
    localparam int N_TOT_W = 15;
    localparam int R_W = 14;
    localparam logic [14:0] TR_OFFSET = 15'h0358;
    localparam logic [13:0] R_RATIO_0 = 14'h0008;
    localparam logic [13:0] R_RATIO_1 = 14'h0080;
    localparam logic [13:0] R_RATIO_2 = 14'h0100;
    localparam logic [13:0] R_RATIO_3 = 14'h0200;
    localparam logic [13:0] R_RATIO_4 = 14'h0400;
    localparam logic [13:0] R_RATIO_5 = 14'h0800;
    localparam logic [13:0] R_RATIO_6 = 14'h096a;
    localparam logic [13:0] R_RATIO_7 = 14'h2000;

endpackage : psd_pkg

// ==== psd_sync.sv ====
`timescale 1ns/10ps
module psd_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    initial begin
        if (W < 1) begin
            $error("psd_sync: W must be at least 1");
        end
    end

    always_comb begin
        meta_d = ce ? async_in : meta_q;
        sync_d = ce ? meta_q : sync_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule : psd_sync

// ==== psd_div.sv ====
`timescale 1ns/10ps
module psd_div #(
    parameter int W = 14
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic tick,
    input wire logic [W-1:0] load_val,
    output logic tc
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic tc_q;
    logic tc_d;

    initial begin
        if (W < 2) begin
            $error("psd_div: W must be at least 2");
        end
    end

    // Count down on each input edge; at the end reload and flag.
    always_comb begin
        cnt_d = cnt_q;
        tc_d = 1'b0;
        if (ce && tick) begin
            if (cnt_q <= W'(1)) begin
                cnt_d = load_val;
                tc_d = 1'b1;
            end else begin
                cnt_d = cnt_q - W'(1);
            end
        end else if (!ce) begin
            tc_d = tc_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            tc_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tc_q <= tc_d;
        end
    end

    assign tc = tc_q;

    chk_div_reload: assert property (@(posedge pclk) disable iff (!presetn)
        ce && tick && cnt_q <= W'(1) |=> cnt_q == $past(load_val))
        else $error("divider did not reload at end of count");

endmodule : psd_div

// ==== psd_core.sv ====
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
// Summary of operation
// - The N counter reloads its programmed value when it runs out.
// - The N counter is 15 bits wide.
// - Programming input bit 0 is the least significant bit of N.
// - The ratio select code picks R from 8 up to 8192.
// - A low transmit/receive input adds 856 to N, high adds nothing.
// - The single error output drives low while fV leads or is faster.
// - The single error output drives high while fV lags or is slower.
// - The single error output floats when fV and fR coincide.
// - The variable-side output pulses low when fV leads.
// - The reference-side output pulses low when fV lags.
// - At coincidence both double outputs give one short low pulse.
// - The N counter output is buffered onto a pin.
// - The lock output is high in lock and pulses low out of lock.
module psd_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic vco_clock_in,
    input wire logic ref_osc_in,
    output logic ref_osc_drive,
    input wire logic [13:0] n_value_inputs,
    input wire logic [2:0] ref_ratio_select,
    input wire logic tr_offset_n,
    output logic single_error_out,
    output logic single_error_oe_n,
    output logic phase_v_out_n,
    output logic phase_r_out_n,
    output logic divided_vco_clock,
    output logic divided_ref_clock,
    output logic lock_indicator
);

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [1:0] clk_s;
    logic [17:0] prog_s;
    logic [1:0] clk_prev_q;
    logic [1:0] clk_prev_d;
    logic fv_edge;
    logic fr_edge;

    psd_sync #(.W(2)) u_clk_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in({ref_osc_in, vco_clock_in}),
        .sync_out(clk_s)
    );

    psd_sync #(.W(18)) u_prog_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in({tr_offset_n, ref_ratio_select, n_value_inputs}),
        .sync_out(prog_s)
    );

    always_comb begin
        clk_prev_d = ce ? clk_s : clk_prev_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_prev_q <= 2'h0;
        end else begin
            clk_prev_q <= clk_prev_d;
        end
    end

    // ------------------------------------------------------------------
    // Registers reached over the bus
    // ------------------------------------------------------------------
    logic [1:0] ctrl_q;
    logic [1:0] ctrl_d;
    logic [3:0] status_q;
    logic [3:0] status_d;
    logic [3:0] mask_q;
    logic [3:0] mask_d;
    logic [17:0] open_q;
    logic [17:0] open_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic irq_q;
    logic irq_d;

    logic run;
    logic wr_go;
    logic rd_go;
    logic hit;
    logic [3:0] events;

    assign run = ctrl_q[psd_pkg::CTRL_RUN_BIT];
    assign fv_edge = run && clk_s[0] && !clk_prev_q[0];
    assign fr_edge = run && clk_s[1] && !clk_prev_q[1];

    // ------------------------------------------------------------------
    // Programmed ratios
    // ------------------------------------------------------------------
    logic [17:0] prog_eff;
    logic [13:0] n_pins;
    logic [2:0] ra_sel;
    logic tr_pin;
    logic [14:0] n_total;
    logic [13:0] r_load;

    always_comb begin
        prog_eff = prog_s | open_q;
        n_pins = prog_eff[13:0];
        ra_sel = prog_eff[16:14];
        tr_pin = prog_eff[17];
        n_total = {1'b0, n_pins} + (tr_pin ? 15'h0000 : psd_pkg::TR_OFFSET);
        case (ra_sel)
            3'h0: r_load = psd_pkg::R_RATIO_0;
            3'h1: r_load = psd_pkg::R_RATIO_1;
            3'h2: r_load = psd_pkg::R_RATIO_2;
            3'h3: r_load = psd_pkg::R_RATIO_3;
            3'h4: r_load = psd_pkg::R_RATIO_4;
            3'h5: r_load = psd_pkg::R_RATIO_5;
            3'h6: r_load = psd_pkg::R_RATIO_6;
            default: r_load = psd_pkg::R_RATIO_7;
        endcase
    end

    // ------------------------------------------------------------------
    // Dividers
    // ------------------------------------------------------------------
    logic fv_tick;
    logic fr_tick;

    // The N path is one bit wider so the offset sum fits.
    psd_div #(.W(psd_pkg::N_TOT_W)) u_n_div (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tick(fv_edge),
        .load_val(n_total),
        .tc(fv_tick)
    );

    psd_div #(.W(psd_pkg::R_W)) u_r_div (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tick(fr_edge),
        .load_val(r_load),
        .tc(fr_tick)
    );

    // ------------------------------------------------------------------
    // Phase/frequency detector and lock detector
    // ------------------------------------------------------------------
    logic up_q;
    logic up_d;
    logic dn_q;
    logic dn_d;
    logic up_set;
    logic dn_set;
    logic coinc;
    logic pd_off;
    logic pe_out_q;
    logic pe_out_d;
    logic pe_oe_n_q;
    logic pe_oe_n_d;
    logic pv_n_q;
    logic pv_n_d;
    logic pr_n_q;
    logic pr_n_d;
    logic fv_out_q;
    logic fv_out_d;
    logic fr_out_q;
    logic fr_out_d;
    logic lock_q;
    logic lock_d;
    logic osc_drv_q;
    logic osc_drv_d;

    assign pd_off = ctrl_q[psd_pkg::CTRL_PD_OFF_BIT];

    // An fR edge arms the up request, an fV edge the down request; when
    // both are armed they cancel, which leaves the short coincidence pulse.
    always_comb begin
        up_set = up_q | fr_tick;
        dn_set = dn_q | fv_tick;
        coinc = up_set & dn_set;
        up_d = coinc ? 1'b0 : up_set;
        dn_d = coinc ? 1'b0 : dn_set;
        pv_n_d = !(dn_d || coinc);
        pr_n_d = !(up_d || coinc);
        pe_out_d = pe_out_q;
        pe_oe_n_d = 1'b1;
        if (!pd_off && dn_d) begin
            pe_out_d = 1'b0;
            pe_oe_n_d = 1'b0;
        end else if (!pd_off && up_d) begin
            pe_out_d = 1'b1;
            pe_oe_n_d = 1'b0;
        end
        lock_d = !(up_d || dn_d);
        fv_out_d = fv_tick;
        fr_out_d = fr_tick;
        osc_drv_d = !clk_s[1];
        if (!ce) begin
            up_d = up_q;
            dn_d = dn_q;
            pv_n_d = pv_n_q;
            pr_n_d = pr_n_q;
            pe_out_d = pe_out_q;
            pe_oe_n_d = pe_oe_n_q;
            lock_d = lock_q;
            fv_out_d = fv_out_q;
            fr_out_d = fr_out_q;
            osc_drv_d = osc_drv_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
            pv_n_q <= 1'b1;
            pr_n_q <= 1'b1;
            pe_out_q <= 1'b0;
            pe_oe_n_q <= 1'b1;
            lock_q <= 1'b1;
            fv_out_q <= 1'b0;
            fr_out_q <= 1'b0;
            osc_drv_q <= 1'b1;
        end else begin
            up_q <= up_d;
            dn_q <= dn_d;
            pv_n_q <= pv_n_d;
            pr_n_q <= pr_n_d;
            pe_out_q <= pe_out_d;
            pe_oe_n_q <= pe_oe_n_d;
            lock_q <= lock_d;
            fv_out_q <= fv_out_d;
            fr_out_q <= fr_out_d;
            osc_drv_q <= osc_drv_d;
        end
    end

    // ------------------------------------------------------------------
    // APB slave, status and interrupt
    // ------------------------------------------------------------------
    always_comb begin
        hit = (paddr == psd_pkg::CTRL_OFS) || (paddr == psd_pkg::STATUS_OFS)
            || (paddr == psd_pkg::MASK_OFS) || (paddr == psd_pkg::LIVE_OFS)
            || (paddr == psd_pkg::OPEN_OFS);
        wr_go = ce && psel && penable && pready_q && pwrite;
        rd_go = ce && psel && penable && pready_q && !pwrite;
        events = 4'h0;
        events[psd_pkg::ST_LOCK_LOST_BIT] = lock_q && !lock_d;
        events[psd_pkg::ST_LOCK_GAIN_BIT] = !lock_q && lock_d;
        events[psd_pkg::ST_FV_BIT] = fv_tick;
        events[psd_pkg::ST_FR_BIT] = fr_tick;
        if (!ce) begin
            events = 4'h0;
        end
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        open_d = open_q;
        status_d = status_q;
        if (rd_go && paddr == psd_pkg::STATUS_OFS) begin
            status_d = 4'h0;
        end
        status_d = status_d | events;
        if (wr_go && paddr == psd_pkg::CTRL_OFS) begin
            ctrl_d = pwdata[1:0];
        end
        if (wr_go && paddr == psd_pkg::MASK_OFS) begin
            mask_d = pwdata[psd_pkg::ST_W-1:0];
        end
        if (wr_go && paddr == psd_pkg::OPEN_OFS) begin
            open_d = pwdata[17:0];
        end
        pready_d = pready_q;
        pslverr_d = pslverr_q;
        prdata_d = prdata_q;
        if (ce) begin
            pready_d = psel && penable && !pready_q;
            pslverr_d = psel && penable && !pready_q && !hit;
            prdata_d = 32'h00000000;
            if (psel && penable && !pready_q && !pwrite) begin
                case (paddr)
                    psd_pkg::CTRL_OFS: prdata_d[1:0] = ctrl_q;
                    psd_pkg::STATUS_OFS: prdata_d[3:0] = status_q;
                    psd_pkg::MASK_OFS: prdata_d[3:0] = mask_q;
                    psd_pkg::LIVE_OFS: begin
                        prdata_d[14:0] = n_total;
                        prdata_d[psd_pkg::LIVE_RA_POS +: 3] = ra_sel;
                        prdata_d[psd_pkg::LIVE_LOCK_POS] = lock_q;
                    end
                    psd_pkg::OPEN_OFS: prdata_d[17:0] = open_q;
                    default: prdata_d = 32'h00000000;
                endcase
            end
        end
        irq_d = ce ? |(status_d & mask_d) : irq_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= psd_pkg::CTRL_RST;
            status_q <= 4'h0;
            mask_q <= psd_pkg::MASK_RST;
            open_q <= psd_pkg::OPEN_RST;
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            status_q <= status_d;
            mask_q <= mask_d;
            open_q <= open_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign ref_osc_drive = osc_drv_q;
    assign single_error_out = pe_out_q;
    assign single_error_oe_n = pe_oe_n_q;
    assign phase_v_out_n = pv_n_q;
    assign phase_r_out_n = pr_n_q;
    assign divided_vco_clock = fv_out_q;
    assign divided_ref_clock = fr_out_q;
    assign lock_indicator = lock_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_ratio_code: assert property (
        (ra_sel == 3'h6 |-> r_load == 14'h096a)
        and (ra_sel == 3'h7 |-> r_load == 14'h2000))
        else $error("reference ratio does not match select code");
    chk_tr_offset: assert property (
        n_total == (tr_pin ? {1'b0, n_pins} : {1'b0, n_pins} + 15'h0358))
        else $error("offset sum is wrong");
    chk_pd_lead: assert property (
        ce && fv_tick && !fr_tick && !up_q && !pd_off
        |=> !single_error_out && !single_error_oe_n)
        else $error("error output not driven low on fV lead");
    chk_pd_lag: assert property (
        ce && fr_tick && !fv_tick && !dn_q && !pd_off
        |=> single_error_out && !single_error_oe_n)
        else $error("error output not driven high on fV lag");
    chk_pd_float: assert property (
        ce && !up_q && !dn_q && !fv_tick && !fr_tick |=> single_error_oe_n)
        else $error("error output driven with nothing pending");
    chk_dual_lead: assert property (
        ce && fv_tick && !fr_tick && !up_q |=> !phase_v_out_n && phase_r_out_n)
        else $error("variable-side output wrong on fV lead");
    chk_dual_lag: assert property (
        ce && fr_tick && !fv_tick && !dn_q |=> phase_v_out_n && !phase_r_out_n)
        else $error("reference-side output wrong on fV lag");
    chk_dual_coinc: assert property (
        ce && fv_tick && fr_tick && !up_q && !dn_q
        |=> !phase_v_out_n && !phase_r_out_n && lock_indicator)
        else $error("coincidence pulse missing");
    chk_fv_out: assert property (
        ce && fv_tick |=> divided_vco_clock)
        else $error("divided clock output missed a terminal count");
    chk_lock_low: assert property (
        ce && (up_d || dn_d) |=> !lock_indicator ##1 (lock_indicator || up_q
            || dn_q || !ce))
        else $error("lock output wrong while out of lock");
    chk_irq_level: assert property (
        ce && |(status_q & mask_q) && !rd_go |=> irq)
        else $error("interrupt low with unmasked status set");

    cov_coinc: cover property (ce && fv_tick && fr_tick && !up_q && !dn_q);
    cov_lead: cover property (ce && dn_q ##1 !single_error_oe_n);
    cov_lag: cover property (ce && up_q ##1 single_error_out);
    cov_irq: cover property (irq ##1 !irq);

endmodule : psd_core

// ==== psd_loop_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Reference source and VCO
// ----------------------------------------------------------------------
// Both sources run free from 37 ns so that their edges never meet pclk.
// With same_src high the reference also feeds the VCO pin.
module psd_loop_model (
    input wire logic same_src,
    input wire logic [15:0] vco_half_ns,
    input wire logic [15:0] ref_half_ns,
    output logic vco_clock_in,
    output logic ref_osc_in
);
    logic ref_q;
    logic vco_q;

    initial begin
        ref_q = 1'b0;
        #37;
        forever begin
            #(ref_half_ns);
            ref_q = ~ref_q;
        end
    end

    initial begin
        vco_q = 1'b0;
        #37;
        forever begin
            #(vco_half_ns);
            vco_q = ~vco_q;
        end
    end

    assign ref_osc_in = ref_q;
    assign vco_clock_in = same_src ? ref_q : vco_q;
endmodule : psd_loop_model

// ==== pll_synth_divider_phase_det_tb.sv ====
`timescale 1ns/10ps
module pll_synth_divider_phase_det_tb;
    localparam int LIMIT = 90000;
    logic pclk;
    logic presetn;
    logic ce;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic vco_clock_in;
    logic ref_osc_in;
    logic ref_osc_drive;
    logic [13:0] n_value_inputs;
    logic [2:0] ref_ratio_select;
    logic tr_offset_n;
    logic single_error_out;
    logic single_error_oe_n;
    logic phase_v_out_n;
    logic phase_r_out_n;
    logic divided_vco_clock;
    logic divided_ref_clock;
    logic lock_indicator;
    logic same_src;
    logic [15:0] vco_half_ns;
    logic [15:0] ref_half_ns;
    logic [31:0] rd;
    logic err;
    int errors;
    int samples_checked;
    int cycles;
    int cnt_v, cnt_r, cnt_both, cnt_lk, cnt_oe, cnt_lvl, cnt_sym;

    psd_core dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq, .vco_clock_in,
        .ref_osc_in, .ref_osc_drive, .n_value_inputs, .ref_ratio_select,
        .tr_offset_n, .single_error_out, .single_error_oe_n, .phase_v_out_n,
        .phase_r_out_n, .divided_vco_clock, .divided_ref_clock,
        .lock_indicator);

    psd_loop_model loop (.same_src, .vco_half_ns, .ref_half_ns,
        .vco_clock_in, .ref_osc_in);

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic c, input string m);
        samples_checked++;
        if (c !== 1'b1) begin
            errors++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask : chk

    task automatic summarize;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk(n < 50, "no bus answer");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e, input string s);
        apb(1'b0, a, 32'h0);
        chk((rd & m) === e && err === 1'b0, s);
    endtask : rdc

    task automatic set_n(input logic [13:0] v, input logic t);
        n_value_inputs <= v;
        tr_offset_n <= t;
        repeat (4) @(posedge pclk);
    endtask : set_n

    task automatic do_reset;
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        chk(pready === 1'b0 && irq === 1'b0 && ref_osc_drive === 1'b1
            && single_error_oe_n === 1'b1 && lock_indicator === 1'b1
            && phase_v_out_n === 1'b1 && phase_r_out_n === 1'b1
            && divided_vco_clock === 1'b0, "reset outputs");
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : do_reset

    task automatic wait_pulse(input logic sel, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((sel ? divided_ref_clock : divided_vco_clock) !== 1'b1
                   && n < 40000);
    endtask : wait_pulse

    // The first two pulses let a new setting reach the reload value.
    task automatic measure(input logic sel, input int e, input string s);
        int n;
        wait_pulse(sel, n);
        wait_pulse(sel, n);
        wait_pulse(sel, n);
        chk(n >= e - 1 && n <= e + 1, s);
    endtask : measure

    task automatic observe(input logic lvl);
        cnt_v = 0;
        cnt_r = 0;
        cnt_both = 0;
        cnt_lk = 0;
        cnt_oe = 0;
        cnt_lvl = 0;
        cnt_sym = 0;
        repeat (400) begin
            @(posedge pclk);
            // A low on one side alone is error; both low is coincidence.
            cnt_v += int'(phase_v_out_n === 1'b0 && phase_r_out_n === 1'b1);
            cnt_r += int'(phase_r_out_n === 1'b0 && phase_v_out_n === 1'b1);
            cnt_both += int'(phase_v_out_n === 1'b0
                             && phase_r_out_n === 1'b0);
            cnt_lk += int'(lock_indicator === 1'b0);
            cnt_oe += int'(single_error_oe_n === 1'b0);
            cnt_lvl += int'(single_error_oe_n === 1'b0
                            && single_error_out !== lvl);
            cnt_sym += int'(phase_v_out_n !== phase_r_out_n
                            || divided_vco_clock !== divided_ref_clock);
        end
    endtask : observe

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        rdc(psd_pkg::CTRL_OFS, 32'h3, 32'h1, "ctrl reset");
        rdc(psd_pkg::MASK_OFS, 32'hf, 32'h0, "mask reset");
        rdc(psd_pkg::OPEN_OFS, 32'h3ffff, 32'h0, "open reset");
        apb(1'b0, 8'h20, 32'h0);
        chk(err === 1'b1 && rd === 32'h0, "unmapped read");
    endtask : t_regs

    task automatic t_ndiv;
        set_n(14'h2000, 1'b1);
        rdc(psd_pkg::LIVE_OFS, 32'h7fff, 32'h2000, "n msb");
        set_n(14'h3fff, 1'b0);
        rdc(psd_pkg::LIVE_OFS, 32'h7fff, 32'd17239, "n max");
        apb(1'b1, psd_pkg::OPEN_OFS, 32'h23fff);
        set_n(14'h0000, 1'b0);
        rdc(psd_pkg::OPEN_OFS, 32'h3ffff, 32'h23fff, "open rw");
        rdc(psd_pkg::LIVE_OFS, 32'h7fff, 32'd16383, "open pins");
        set_n(14'h0005, 1'b1);
        do_reset();
        rdc(psd_pkg::LIVE_OFS, 32'h7fff, 32'h5, "n lsb");
        measure(1'b0, 20, "fV period n=5");
        set_n(14'h0005, 1'b0);
        rdc(psd_pkg::LIVE_OFS, 32'h7fff, 32'd861, "n offset");
        measure(1'b0, 3444, "fV period offset");
    endtask : t_ndiv

    task automatic t_ratio;
        int ratio [8] = '{8, 128, 256, 512, 1024, 2048, 2410, 8192};
        for (int c = 0; c < 8; c++) begin
            ref_ratio_select <= 3'(c);
            repeat (4) @(posedge pclk);
            rdc(psd_pkg::LIVE_OFS, 32'h70000, 32'(c) << 16, "code");
            if (c == 0 || c == 1 || c == 6) begin
                measure(1'b1, ratio[c] * 4, "fR period");
            end
        end
    endtask : t_ratio

    task automatic t_phase;
        logic [4:0] snap;
        set_n(14'h0003, 1'b1);
        ref_ratio_select <= 3'h0;
        do_reset();
        repeat (100) @(posedge pclk);
        observe(1'b0);
        chk(cnt_v > 0 && cnt_r == 0 && cnt_lk > 0, "fV fast");
        chk(cnt_oe > 0 && cnt_lvl == 0, "fast level");
        apb(1'b1, psd_pkg::CTRL_OFS, 32'h3);
        observe(1'b0);
        chk(cnt_oe == 0 && cnt_v > 0, "error output switched off");
        apb(1'b1, psd_pkg::CTRL_OFS, 32'h1);
        ce <= 1'b0;
        repeat (2) @(posedge pclk);
        snap = {phase_v_out_n, phase_r_out_n, lock_indicator,
                single_error_oe_n, divided_vco_clock};
        repeat (40) @(posedge pclk);
        chk(snap === {phase_v_out_n, phase_r_out_n, lock_indicator,
                      single_error_oe_n, divided_vco_clock}, "ce freeze");
        ce <= 1'b1;
        vco_half_ns <= 16'd2000;
        repeat (400) @(posedge pclk);
        observe(1'b1);
        chk(cnt_r > 0 && cnt_v == 0 && cnt_lk > 0, "fV slow");
        chk(cnt_oe > 0 && cnt_lvl == 0, "slow level");
    endtask : t_phase

    task automatic t_coin;
        same_src <= 1'b1;
        set_n(14'h0008, 1'b1);
        do_reset();
        observe(1'b0);
        chk(cnt_sym == 0 && cnt_both > 0, "both pulse together");
        chk(cnt_oe == 0 && cnt_lk == 0, "coincidence quiet");
        same_src <= 1'b0;
    endtask : t_coin

    task automatic t_irq;
        int n;
        vco_half_ns <= 16'd200;
        set_n(14'h0003, 1'b1);
        repeat (200) @(posedge pclk);
        apb(1'b1, psd_pkg::MASK_OFS, 32'h0);
        repeat (3) @(posedge pclk);
        chk(irq === 1'b0, "irq masked");
        apb(1'b1, psd_pkg::MASK_OFS, 32'h1);
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk(irq === 1'b1, "irq raised");
        apb(1'b1, psd_pkg::CTRL_OFS, 32'h0);
        repeat (5) @(posedge pclk);
        rdc(psd_pkg::STATUS_OFS, 32'h1, 32'h1, "lock lost sticky");
        repeat (3) @(posedge pclk);
        chk(irq === 1'b0, "irq cleared");
        rdc(psd_pkg::STATUS_OFS, 32'hf, 32'h0, "status cleared");
        apb(1'b1, psd_pkg::CTRL_OFS, 32'h1);
    endtask : t_irq

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            $display("CHECK FAILED t=%0t run too long", $time);
            summarize();
        end
    end

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_value_inputs = 14'h0005;
        ref_ratio_select = 3'h0;
        tr_offset_n = 1'b1;
        same_src = 1'b0;
        vco_half_ns = 16'd200;
        ref_half_ns = 16'd200;
        do_reset();
        t_regs();
        t_ndiv();
        t_ratio();
        t_phase();
        t_coin();
        t_irq();
        summarize();
    end
endmodule : pll_synth_divider_phase_det_tb
